// File: afch_buf.sv
// small frame byte memory with registered read data
module afch_buf #(
  parameter int DEPTH = 16,
  parameter int AW    = 4
) (
  // clock
  input  wire logic          mclk,
  // write side
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [7:0]    wr_data,
  // read side
  input  wire logic [AW-1:0] rd_addr,
  output logic      [7:0]    rd_data
);
  logic [7:0] mem [DEPTH];

  // write and registered read
  always_ff @(posedge mclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule

// File: afch_host.sv
// host processor model: accepts response frames and keeps the last known one
module afch_host (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       sys_rst,
  // device byte stream
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_byte,
  output logic            tx_ready,
  // stall control
  input  wire logic       slow
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] acc [0:19];
  logic [7:0] fr [0:19];
  int         pos;
  int         len;
  int         n_fr;

  // accept toggles when slow, to stretch every byte of the answer
  initial tx_ready = 1'b0;
  always @(negedge mclk) tx_ready <= slow ? ~tx_ready : 1'b1;

  // frame capture; unknown types are dropped quietly, new types may appear
  always @(posedge mclk) begin
    if (sys_rst) begin
      pos = 0;
      n_fr = 0;
    end else if (tx_valid && tx_ready && !(pos == 0 && tx_byte !== 8'h7E)) begin
      acc[pos] = tx_byte;
      pos++;
      if (pos == 3) len = {acc[1], acc[2]};
      if (pos > 3 && (pos == len + 4 || pos == 20)) begin
        pos = 0;
        if (acc[3] inside {8'h88, 8'h8A, 8'h8B, 8'h90, 8'h91, 8'h97}) begin
          fr = acc;
          n_fr++;
        end
      end
    end
  end
endmodule

// File: afch_pkg.sv
// package of frame constants for the api frame command handler
// Behaviour
// - frame id at byte 4; zero id suppresses every response frame except the length and checksum status frames
// - emit transmit-status after each data transmission unless its frame id was zero; tx_done is dropped unless the framer is idle with no start delimiter arriving
// - transmit-status carries the delivery failure code when delivery fails
// - received radio data reported as type 0x90 or 0x91 by format setting
// - no remote-command response when the remote never received the command
// - type 0x08 queries or sets a parameter then applies all pending changes
// - length in bytes 1 and 2, msb first, counts bytes before checksum
// - bytes 5 and 6 hold the two ascii command name characters
// - bytes after the name are the value; none means a read query
// - checksum is 0xff minus low eight bits of sum from byte 3
// - type 0x09 writes stay pending until 0x08 or apply command
// - read queries in a 0x09 frame are answered at once
// - pending serial rate does not take effect before apply
// - values of one, two or four bytes are interpreted identically
// - bytes before the start delimiter are silently dropped
// - malformed or bad-checksum frames get a status frame naming the failure
// - multi-byte payload fields travel most significant byte first
package afch_pkg;
  localparam logic [7:0] START_DELIM   = 8'h7E;
  localparam logic [7:0] FT_CMD        = 8'h08;
  localparam logic [7:0] FT_CMD_QUEUE  = 8'h09;
  localparam logic [7:0] FT_TX_REQ     = 8'h10;
  localparam logic [7:0] FT_REMOTE_REQ = 8'h17;
  localparam logic [7:0] FT_CMD_RESP   = 8'h88;
  localparam logic [7:0] FT_STATUS     = 8'h8A;
  localparam logic [7:0] FT_TX_STATUS  = 8'h8B;
  localparam logic [7:0] FT_RX_PLAIN   = 8'h90;
  localparam logic [7:0] FT_RX_EXPL    = 8'h91;
  localparam logic [7:0] FT_REMOTE_RSP = 8'h97;
  localparam logic [7:0] CSUM_BASE     = 8'hFF;
  // status codes carried in the status and response frames
  localparam logic [7:0] ST_BAD_CSUM   = 8'h01;
  localparam logic [7:0] ST_BAD_LEN    = 8'h02;
  localparam logic [7:0] ST_OK         = 8'h00;
  localparam logic [7:0] ST_BAD_CMD    = 8'h02;
  localparam logic [15:0] MAX_LEN      = 16'h0010;
  // parameter table: ascii names
  localparam logic [15:0] NAME_FMT     = 16'h4150;
  localparam logic [15:0] NAME_APPLY   = 16'h4143;
  localparam logic [15:0] NAME_JOIN    = 16'h4E4A;
  localparam logic [15:0] NAME_RATE    = 16'h4244;
  localparam int PARAM_CNT             = 3;
  localparam int IDX_FMT               = 0;
  localparam int IDX_JOIN              = 1;
  localparam int IDX_RATE              = 2;
  localparam logic [31:0] RST_FMT      = 32'h0000_0001;
  localparam logic [31:0] RST_JOIN     = 32'h0000_00FF;
  localparam logic [31:0] RST_RATE     = 32'h0000_0003;
  localparam int BUF_DEPTH             = 16;
  localparam int BUF_AW                = 4;
endpackage

// File: afch_top.sv
// frame parser, parameter executor and response framer
module afch_top (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  // host byte stream in
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_byte,
  // host byte stream out
  output logic             tx_valid,
  input  wire logic        tx_ready,
  output logic      [7:0]  tx_byte,
  // radio-side events
  input  wire logic        tx_done,
  input  wire logic [7:0]  tx_done_id,
  input  wire logic [7:0]  tx_done_code,
  input  wire logic        rrsp_done,
  input  wire logic        rrsp_delivered,
  input  wire logic [7:0]  rrsp_id,
  // active settings
  output logic      [7:0]  frame_format_select,
  output logic      [7:0]  join_permit_time,
  output logic      [7:0]  serial_rate_setting,
  output logic      [7:0]  rx_frame_type
);
  typedef enum logic [3:0] {
    S_IDLE  = 4'b0000,
    S_LENH  = 4'b0001,
    S_LENL  = 4'b0010,
    S_DATA  = 4'b0011,
    S_CSUM  = 4'b0100,
    S_EXEC  = 4'b0101,
    S_SEND  = 4'b0110
  } afch_state_t;

  typedef struct packed {
    afch_state_t st;
    logic [15:0] len;
    logic [15:0] cnt;
    logic [7:0]  sum;
    logic [7:0]  ftype;
    logic [7:0]  fid;
    logic [15:0] name;
    logic [31:0] val;
    logic [2:0]  vcnt;
    logic [31:0] act_fmt;
    logic [31:0] act_join;
    logic [31:0] act_rate;
    logic [31:0] pend_fmt;
    logic [31:0] pend_join;
    logic [31:0] pend_rate;
    logic [2:0]  dirty;
    // outgoing frame: type, id, status, value byte
    logic [7:0]  o_type;
    logic [7:0]  o_id;
    logic [7:0]  o_code;
    logic [7:0]  o_val;
    logic        o_hasval;
    logic [2:0]  o_pos;
    logic [7:0]  o_sum;
    logic        tx_v;
    logic [7:0]  tx_b;
  } afch_state_s_t;

  afch_state_s_t s, next_s;

  // two-flop catch of the host stream pins
  logic       rxv_m, rxv;
  logic [7:0] rxb_m, rxb;
  always_ff @(posedge mclk) begin
    rxv_m <= rx_valid;
    rxb_m <= rx_byte;
    rxv   <= rxv_m;
    rxb   <= rxb_m;
  end

  // keep the last few payload bytes for debugging reads
  logic [7:0] buf_q;
  afch_buf #(.DEPTH(afch_pkg::BUF_DEPTH), .AW(afch_pkg::BUF_AW)) u_buf (
    .mclk    (mclk),
    .wr_en   (rxv && s.st == S_DATA),
    .wr_addr (s.cnt[afch_pkg::BUF_AW-1:0]),
    .wr_data (rxb),
    .rd_addr (s.cnt[afch_pkg::BUF_AW-1:0]),
    .rd_data (buf_q)
  );

  // start an outgoing frame unless the id asks for silence
  function automatic afch_state_s_t queue_frame(afch_state_s_t x, logic [7:0] t,
      logic [7:0] id, logic [7:0] code, logic [7:0] v, logic hv, logic force_out);
    afch_state_s_t y;
    y = x;
    if (id != 8'h00 || force_out) begin
      y.o_type   = t;
      y.o_id     = id;
      y.o_code   = code;
      y.o_val    = v;
      y.o_hasval = hv;
      y.o_pos    = 3'd0;
      y.st       = S_SEND;
    end else begin
      y.st = S_IDLE;
    end
    return y;
  endfunction

  // byte to emit at a given position of the outgoing frame
  function automatic logic [7:0] frame_byte(afch_state_s_t x);
    logic [7:0] r;
    r = 8'h00;
    case (x.o_pos)
      3'd0: r = afch_pkg::START_DELIM;
      3'd1: r = 8'h00;
      3'd2: r = x.o_hasval ? 8'h04 : 8'h03;
      3'd3: r = x.o_type;
      3'd4: r = x.o_id;
      3'd5: r = x.o_code;
      3'd6: r = x.o_hasval ? x.o_val : afch_pkg::CSUM_BASE - x.o_sum;
      default: r = afch_pkg::CSUM_BASE - x.o_sum;
    endcase
    return r;
  endfunction

  logic [7:0]  csum_next;
  logic        is_read;
  logic        known;
  logic        is_param;
  logic [31:0] cur_val;
  assign csum_next = s.sum + rxb;
  assign is_read   = (s.vcnt == 3'd0);
  assign known     = s.name == afch_pkg::NAME_FMT || s.name == afch_pkg::NAME_JOIN
                  || s.name == afch_pkg::NAME_RATE || s.name == afch_pkg::NAME_APPLY;
  // apply names no parameter, so it never answers with a value byte
  assign is_param  = known && s.name != afch_pkg::NAME_APPLY;
  assign cur_val   = (s.name == afch_pkg::NAME_FMT)  ? s.act_fmt  :
                     (s.name == afch_pkg::NAME_JOIN) ? s.act_join : s.act_rate;

  // next-state logic
  always_comb begin
    next_s    = s;
    next_s.tx_v = 1'b0;
    case (s.st)
      S_IDLE: begin
        if (rxv && rxb == afch_pkg::START_DELIM) begin
          next_s.st = S_LENH;
        end
      end
      S_LENH: if (rxv) begin
        next_s.len[15:8] = rxb;
        next_s.st = S_LENL;
      end
      S_LENL: if (rxv) begin
        next_s.len[7:0] = rxb;
        next_s.cnt  = 16'h0000;
        next_s.sum  = 8'h00;
        next_s.val  = 32'h0000_0000;
        next_s.vcnt = 3'd0;
        next_s.name = 16'h0000;
        next_s.fid  = 8'h00;
        if ({s.len[15:8], rxb} == 16'h0000 || {s.len[15:8], rxb} > afch_pkg::MAX_LEN) begin
          next_s = queue_frame(next_s, afch_pkg::FT_STATUS, 8'h00, afch_pkg::ST_BAD_LEN,
                               8'h00, 1'b0, 1'b1);
        end else begin
          next_s.st = S_DATA;
        end
      end
      S_DATA: if (rxv) begin
        next_s.sum = csum_next;
        next_s.cnt = s.cnt + 16'h0001;
        case (s.cnt)
          16'h0000: next_s.ftype = rxb;
          16'h0001: next_s.fid = rxb;
          16'h0002: next_s.name[15:8] = rxb;
          16'h0003: next_s.name[7:0] = rxb;
          default: begin
            next_s.val  = {s.val[23:0], rxb};
            next_s.vcnt = s.vcnt + 3'd1;
          end
        endcase
        if (s.cnt + 16'h0001 == s.len) begin
          next_s.st = S_CSUM;
        end
      end
      S_CSUM: if (rxv) begin
        if (csum_next != afch_pkg::CSUM_BASE) begin
          next_s = queue_frame(s, afch_pkg::FT_STATUS, 8'h00, afch_pkg::ST_BAD_CSUM,
                               8'h00, 1'b0, 1'b1);
        end else begin
          next_s.st = S_EXEC;
        end
      end
      S_EXEC: begin
        if (s.ftype == afch_pkg::FT_CMD || s.ftype == afch_pkg::FT_CMD_QUEUE) begin
          if (!is_read) begin
            // writes always land in the pending copy first
            case (s.name)
              afch_pkg::NAME_FMT:  begin next_s.pend_fmt  = s.val; next_s.dirty[0] = 1'b1; end
              afch_pkg::NAME_JOIN: begin next_s.pend_join = s.val; next_s.dirty[1] = 1'b1; end
              afch_pkg::NAME_RATE: begin next_s.pend_rate = s.val; next_s.dirty[2] = 1'b1; end
              default: ;
            endcase
          end
          if (s.ftype == afch_pkg::FT_CMD || s.name == afch_pkg::NAME_APPLY) begin
            // apply: rate change waits until here
            next_s.act_fmt  = next_s.pend_fmt;
            next_s.act_join = next_s.pend_join;
            next_s.act_rate = next_s.pend_rate;
            next_s.dirty    = 3'b000;
          end
          // reads answer at once from active value
          next_s = queue_frame(next_s, afch_pkg::FT_CMD_RESP, s.fid,
                               known ? afch_pkg::ST_OK : afch_pkg::ST_BAD_CMD,
                               cur_val[7:0], is_read && is_param, 1'b0);
        end else begin
          next_s.st = S_IDLE; // other types are dropped here without a response
        end
      end
      S_SEND: begin
        next_s.tx_v = 1'b1;
        next_s.tx_b = frame_byte(s);
        if (s.tx_v && tx_ready) begin
          if (s.o_pos >= 3'd3) begin
            next_s.o_sum = s.o_sum + s.tx_b;
          end
          if ((s.o_hasval && s.o_pos == 3'd7) || (!s.o_hasval && s.o_pos == 3'd6)) begin
            next_s.st   = S_IDLE;
            next_s.tx_v = 1'b0;
          end else begin
            next_s.o_pos = s.o_pos + 3'd1;
            next_s.tx_b  = frame_byte(next_s);
          end
        end
      end
      default: next_s.st = S_IDLE;
    endcase
    // radio events only when the framer is free
    if (s.st == S_IDLE && !(rxv && rxb == afch_pkg::START_DELIM)) begin
      if (tx_done) begin
        next_s = queue_frame(s, afch_pkg::FT_TX_STATUS, tx_done_id, tx_done_code,
                             8'h00, 1'b0, 1'b0);
      end else if (rrsp_done && rrsp_delivered) begin
        next_s = queue_frame(s, afch_pkg::FT_REMOTE_RSP, rrsp_id, afch_pkg::ST_OK,
                             8'h00, 1'b0, 1'b0);
      end
    end
    if (next_s.st == S_SEND && s.st != S_SEND) begin
      next_s.o_sum = 8'h00;
    end
  end

  // state register
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      s           <= '0;
      s.st        <= S_IDLE;
      s.act_fmt   <= afch_pkg::RST_FMT;
      s.act_join  <= afch_pkg::RST_JOIN;
      s.act_rate  <= afch_pkg::RST_RATE;
      s.pend_fmt  <= afch_pkg::RST_FMT;
      s.pend_join <= afch_pkg::RST_JOIN;
      s.pend_rate <= afch_pkg::RST_RATE;
    end else begin
      s <= next_s;
    end
  end

  assign tx_valid            = s.tx_v;
  assign tx_byte             = s.tx_b;
  assign frame_format_select = s.act_fmt[7:0];
  assign join_permit_time    = s.act_join[7:0];
  assign serial_rate_setting = s.act_rate[7:0];
  // received data type follows the active format
  assign rx_frame_type = (s.act_fmt[7:0] == 8'h01) ? afch_pkg::FT_RX_EXPL
                                                   : afch_pkg::FT_RX_PLAIN;

  // zero frame id on a transmit-status event gives no frame
  property p_silent_zero_id;
    @(posedge mclk) disable iff (sys_rst)
      (s.st == S_IDLE && tx_done && tx_done_id == 8'h00 && !rxv) |=> s.st == S_IDLE;
  endproperty
  a_silent_zero_id: assert property (p_silent_zero_id) else $error("response sent for id 0");

  // queued write leaves the active rate alone
  property p_rate_held;
    @(posedge mclk) disable iff (sys_rst)
      (s.st == S_EXEC && s.ftype == afch_pkg::FT_CMD_QUEUE && s.name == afch_pkg::NAME_RATE)
      |=> $stable(s.act_rate);
  endproperty
  a_rate_held: assert property (p_rate_held) else $error("rate applied too early");

  // command frame applies pending values
  property p_apply;
    @(posedge mclk) disable iff (sys_rst)
      (s.st == S_EXEC && s.ftype == afch_pkg::FT_CMD) |=> s.dirty == 3'b000;
  endproperty
  a_apply: assert property (p_apply) else $error("pending not applied");

  // a command with a zero id finishes without a response frame
  property p_silent_cmd;
    @(posedge mclk) disable iff (sys_rst)
      (s.st == S_EXEC && s.fid == 8'h00
       && (s.ftype == afch_pkg::FT_CMD || s.ftype == afch_pkg::FT_CMD_QUEUE))
      |=> s.st == S_IDLE;
  endproperty
  a_silent_cmd: assert property (p_silent_cmd) else $error("command answered for id 0");

  // stray bytes in idle never start a frame
  property p_drop_stray;
    @(posedge mclk) disable iff (sys_rst)
      (s.st == S_IDLE && rxv && rxb != afch_pkg::START_DELIM && !tx_done && !rrsp_done)
      |=> s.st == S_IDLE;
  endproperty
  a_drop_stray: assert property (p_drop_stray) else $error("stray byte started a frame");

  // a failed checksum queues a status frame naming the failure
  property p_bad_csum;
    @(posedge mclk) disable iff (sys_rst)
      (s.st == S_CSUM && rxv && csum_next != afch_pkg::CSUM_BASE)
      |=> (s.st == S_SEND && s.o_type == afch_pkg::FT_STATUS
           && s.o_code == afch_pkg::ST_BAD_CSUM);
  endproperty
  a_bad_csum: assert property (p_bad_csum) else $error("no status for bad checksum");
endmodule

// File: tb_top.sv
// self-checking bench for the frame command handler
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic       mclk, sys_rst, rx_valid, tx_valid, tx_ready, slow;
  logic       tx_done, rrsp_done, rrsp_delivered;
  logic [7:0] rx_byte, tx_byte, tx_done_id, tx_done_code, rrsp_id;
  logic [7:0] fmt, join_t, rate, rx_ft;
  int         n_fail, total_checks, n0, w;

  afch_top u_dut (.mclk(mclk), .sys_rst(sys_rst), .rx_valid(rx_valid), .rx_byte(rx_byte),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_byte(tx_byte), .tx_done(tx_done),
    .tx_done_id(tx_done_id), .tx_done_code(tx_done_code), .rrsp_done(rrsp_done),
    .rrsp_delivered(rrsp_delivered), .rrsp_id(rrsp_id), .frame_format_select(fmt),
    .join_permit_time(join_t), .serial_rate_setting(rate), .rx_frame_type(rx_ft));
  afch_host u_host (.mclk(mclk), .sys_rst(sys_rst), .tx_valid(tx_valid), .tx_byte(tx_byte),
    .tx_ready(tx_ready), .slow(slow));

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  task end_sim();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one byte strobe, then an idle cycle; caller sits at a falling edge
  task send(input logic [7:0] b);
    rx_valid = 1'b1;
    rx_byte = b;
    @(negedge mclk);
    rx_valid = 1'b0;
    @(negedge mclk);
  endtask

  // command frame, value msb first; cs_err spoils the checksum
  task cmd(input logic [7:0] ft, id, input logic [15:0] nm, input logic [31:0] v,
           input int nv, input logic [7:0] cs_err);
    logic [7:0] q[$];
    logic [7:0] s;
    n0 = u_host.n_fr;
    q = {ft, id, nm[15:8], nm[7:0]};
    for (int i = nv - 1; i >= 0; i--) q.push_back(v[8*i+:8]);
    s = 8'h00;
    foreach (q[k]) s += q[k];
    send(8'h7E);
    send(8'h00);
    send(8'(q.size()));
    foreach (q[k]) send(q[k]);
    send(8'hFF - s + cs_err);
  endtask

  // wait for the next host-visible frame and judge its fields
  task resp(input logic [7:0] ft, id, code, input int nv, input logic [7:0] v);
    logic [7:0] s;
    for (int t = 0; t < 400 && u_host.n_fr == n0; t++) @(negedge mclk);
    chk("frame count", 8'(n0 + 1), 8'(u_host.n_fr));
    chk("length", 8'(3 + nv), u_host.fr[2]);
    chk("type", ft, u_host.fr[3]);
    chk("frame id", id, u_host.fr[4]);
    chk("code", code, u_host.fr[5]);
    if (nv > 0) chk("value", v, u_host.fr[6]);
    s = 8'h00;
    for (int i = 3; i <= 3 + u_host.fr[2]; i++) s += u_host.fr[i];
    chk("checksum", 8'hFF, s);
  endtask

  task none();
    repeat (200) @(negedge mclk);
    chk("no frame", 8'(n0), 8'(u_host.n_fr));
  endtask

  task t_read();
    send(8'h13);
    send(8'h00);
    cmd(8'h08, 8'h01, afch_pkg::NAME_JOIN, 0, 0, 8'h00);
    resp(8'h88, 8'h01, 8'h00, 1, 8'hFF);
    $display("test read done");
  endtask

  task t_write();
    for (int k = 0; k < 3; k++) begin
      w = (k == 0) ? 1 : (k == 1) ? 2 : 4;
      cmd(8'h08, 8'(k + 1), afch_pkg::NAME_JOIN, 32'(8'h20 + w), w, 8'h00);
      resp(8'h88, 8'(k + 1), 8'h00, 0, 8'h00);
      chk("join", 8'(8'h20 + w), join_t);
    end
    $display("test write done");
  endtask

  // queued writes under a stalling host
  task t_queue();
    slow = 1'b1;
    cmd(8'h09, 8'h02, afch_pkg::NAME_RATE, 7, 2, 8'h00);
    resp(8'h88, 8'h02, 8'h00, 0, 8'h00);
    chk("rate held", 8'h03, rate);
    cmd(8'h09, 8'h03, afch_pkg::NAME_RATE, 0, 0, 8'h00);
    resp(8'h88, 8'h03, 8'h00, 1, 8'h03);
    cmd(8'h09, 8'h04, afch_pkg::NAME_APPLY, 0, 0, 8'h00);
    resp(8'h88, 8'h04, 8'h00, 0, 8'h00);
    chk("rate applied", 8'h07, rate);
    cmd(8'h09, 8'h05, afch_pkg::NAME_JOIN, 8'h33, 4, 8'h00);
    resp(8'h88, 8'h05, 8'h00, 0, 8'h00);
    chk("join held", 8'h24, join_t);
    cmd(8'h08, 8'h06, afch_pkg::NAME_FMT, 0, 0, 8'h00);
    resp(8'h88, 8'h06, 8'h00, 1, 8'h01);
    chk("join applied", 8'h33, join_t);
    slow = 1'b0;
    $display("test queue done");
  endtask

  task t_fmt();
    for (int v = 0; v < 2; v++) begin
      cmd(8'h08, 8'h07, afch_pkg::NAME_FMT, v, 1, 8'h00);
      resp(8'h88, 8'h07, 8'h00, 0, 8'h00);
      chk("rx type", v ? 8'h91 : 8'h90, rx_ft);
    end
    $display("test format done");
  endtask

  task t_errs();
    cmd(8'h08, 8'h00, afch_pkg::NAME_JOIN, 0, 0, 8'h00);
    none();
    cmd(8'h08, 8'h08, afch_pkg::NAME_JOIN, 0, 0, 8'h01);
    resp(8'h8A, 8'h00, 8'h01, 0, 8'h00);
    n0 = u_host.n_fr;
    send(8'h7E);
    send(8'h00);
    send(8'h00);
    resp(8'h8A, 8'h00, 8'h02, 0, 8'h00);
    cmd(8'h08, 8'h0B, 16'h5858, 0, 0, 8'h00);
    resp(8'h88, 8'h0B, 8'h02, 0, 8'h00);
    $display("test errors done");
  endtask

  // radio-side events: transmit status and remote answers
  task t_events();
    for (int i = 0; i < 2; i++) begin
      n0 = u_host.n_fr;
      tx_done = 1'b1;
      tx_done_id = i ? 8'h00 : 8'h09;
      tx_done_code = 8'h21;
      @(negedge mclk);
      tx_done = 1'b0;
      if (i == 0) resp(8'h8B, 8'h09, 8'h21, 0, 8'h00);
      else none();
      n0 = u_host.n_fr;
      rrsp_done = 1'b1;
      rrsp_delivered = 1'(i);
      rrsp_id = 8'h0A;
      @(negedge mclk);
      rrsp_done = 1'b0;
      if (i == 0) none();
    end
    resp(8'h97, 8'h0A, 8'h00, 0, 8'h00);
    $display("test events done");
  endtask

  initial begin
    repeat (20000) @(posedge mclk);
    n_fail++;
    end_sim();
  end

  initial begin
    {sys_rst, rx_valid, slow, tx_done, rrsp_done, rrsp_delivered} = 6'b100000;
    {rx_byte, tx_done_id, tx_done_code, rrsp_id} = 32'h0000_0000;
    n_fail = 0;
    total_checks = 0;
    repeat (2) @(negedge mclk);
    sys_rst = 1'b0;
    chk("fmt reset", 8'h01, fmt);
    chk("rate reset", 8'h03, rate);
    t_read();
    t_write();
    t_queue();
    t_fmt();
    t_errs();
    t_events();
    end_sim();
  end
endmodule
